// [hw/wdt_top.sv]
// watchdog timer: prescaled 16-bit up counter with prewarning and reset request
// Function
// - The watchdog counts after every reset without software action.
// - The disable instruction stops the counter in the run state (a started prewarning still ends in a reset request) and the enable instruction restarts it.
// - On overflow a prewarning interrupt is raised first and a reset request afterwards.
// - The counter is 16 bits, clocked by the clock divided by 16384 or 256.
// - The counter is loaded from a programmable reload value.
// - Each service in the run state reloads the counter; every service clears the prescaler.
`timescale 1ns/100ps
module wdt_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic watchdogEnableInstruction,
    input wire logic watchdogDisableInstruction,
    input wire logic serviceStrobe,
    input wire logic fastPrescale,
    input wire logic [15:0] watchdogReloadValue,
    output logic prewarnIrq,
    output logic resetRequest,
    output logic running
);
    typedef struct packed {
        logic [1:0] rstSync;
        logic enabled;
        logic [15:0] count;
        wdt_pkg::wdt_state_e state;
        logic [7:0] warnCnt;
        logic irq;
        logic rstReq;
    } wdt_state_s;

    wdt_state_s r_q;
    wdt_state_s r_d;
    logic rstn;
    logic tick;

    assign rstn = r_q.rstSync[1];

    // reset release synchroniser kept outside the main struct reset path
    logic [1:0] rsync_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end

    wdt_prescaler u_pre (
        .clock(clock),
        .rstn(rsync_q[1]),
        .run(r_q.enabled && r_q.state == wdt_pkg::WDT_RUN),
        .clear(serviceStrobe),
        .fastSel(fastPrescale),
        .tick(tick)
    );

    always_comb begin
        r_d = r_q;
        r_d.rstSync = rsync_q;
        r_d.irq = 1'b0;
        if (watchdogDisableInstruction) begin
            r_d.enabled = 1'b0;
        end else if (watchdogEnableInstruction) begin
            r_d.enabled = 1'b1;
        end
        case (r_q.state)
            wdt_pkg::WDT_RUN: begin
                if (serviceStrobe) begin
                    r_d.count = watchdogReloadValue;
                end else if (tick) begin
                    if (r_q.count == 16'hFFFF) begin
                        r_d.count = watchdogReloadValue;
                        r_d.state = wdt_pkg::WDT_WARN;
                        r_d.irq = 1'b1;
                        r_d.warnCnt = wdt_pkg::WARN_CYCLES;
                    end else begin
                        r_d.count = r_q.count + 16'h0001;
                    end
                end
            end
            wdt_pkg::WDT_WARN: begin
                if (r_q.warnCnt == 8'h00) begin
                    r_d.state = wdt_pkg::WDT_RESET;
                    r_d.rstReq = 1'b1;
                end else begin
                    r_d.warnCnt = r_q.warnCnt - 8'h01;
                end
            end
            wdt_pkg::WDT_RESET: begin
                r_d.rstReq = 1'b1;
            end
            default: begin
                r_d.state = wdt_pkg::WDT_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r_q.rstSync <= 2'h0;
            r_q.enabled <= 1'b1;
            r_q.count <= wdt_pkg::CNT_RST;
            r_q.state <= wdt_pkg::WDT_RUN;
            r_q.warnCnt <= 8'h00;
            r_q.irq <= 1'b0;
            r_q.rstReq <= 1'b0;
        end else if (!rsync_q[1]) begin
            r_q.rstSync <= rsync_q;
            r_q.enabled <= 1'b1;
            r_q.count <= wdt_pkg::CNT_RST;
            r_q.state <= wdt_pkg::WDT_RUN;
            r_q.warnCnt <= 8'h00;
            r_q.irq <= 1'b0;
            r_q.rstReq <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign prewarnIrq = r_q.irq;
    assign resetRequest = r_q.rstReq;
    assign running = r_q.enabled;

    a_warn_before_reset: assert property (@(posedge clock) disable iff (!rstn)
        $rose(resetRequest) |-> $past(r_q.state) == wdt_pkg::WDT_WARN)
        else $error("reset request without prior prewarning");
    a_irq_then_reset: assert property (@(posedge clock) disable iff (!rstn)
        prewarnIrq |-> ##[17:18] resetRequest)
        else $error("reset request did not follow prewarning");
    a_service_reload: assert property (@(posedge clock) disable iff (!rstn)
        (serviceStrobe && r_q.state == wdt_pkg::WDT_RUN) |=> r_q.count == $past(watchdogReloadValue))
        else $error("service did not reload counter");
    a_disable_stops: assert property (@(posedge clock) disable iff (!rstn)
        watchdogDisableInstruction |=> !running)
        else $error("disable did not stop watchdog");
    a_enable_starts: assert property (@(posedge clock) disable iff (!rstn)
        (watchdogEnableInstruction && !watchdogDisableInstruction) |=> running)
        else $error("enable did not start watchdog");
    a_stopped_holds: assert property (@(posedge clock) disable iff (!rstn)
        (!running && !serviceStrobe && !watchdogEnableInstruction) |=> $stable(r_q.count))
        else $error("counter moved while disabled");
    a_count_step: assert property (@(posedge clock) disable iff (!rstn)
        (tick && !serviceStrobe && r_q.count != 16'hFFFF) |=> r_q.count == $past(r_q.count) + 16'h0001)
        else $error("counter did not step up");
    a_overflow_irq: assert property (@(posedge clock) disable iff (!rstn)
        (tick && !serviceStrobe && r_q.count == 16'hFFFF) |=> prewarnIrq)
        else $error("overflow without prewarning");
    a_fast_tick: assert property (@(posedge clock) disable iff (!rstn)
        (tick && fastPrescale) |=> !tick)
        else $error("prescaler ticked twice in a row");
    a_irq_single_pulse: assert property (@(posedge clock) disable iff (!rstn)
        prewarnIrq |=> !prewarnIrq)
        else $error("prewarning lasted more than one cycle");
    a_reset_req_holds: assert property (@(posedge clock) disable iff (!rstn)
        resetRequest |=> resetRequest)
        else $error("reset request dropped before reset");
    a_enabled_after_reset: assert property (@(posedge clock)
        $rose(rstn) |-> running)
        else $error("watchdog not enabled after reset");
endmodule

// [hw/wdt_pkg.sv]
// constants and types shared by the watchdog timer design
package wdt_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam int PRE_W = 14;
    localparam int PRE_DIV_SLOW = 16384;
    localparam int PRE_DIV_FAST = 256;
    localparam logic [13:0] PRE_MASK_SLOW = 14'h3FFF;
    localparam logic [13:0] PRE_MASK_FAST = 14'h00FF;
    localparam logic [7:0] WARN_CYCLES = 8'h10;
    typedef enum logic [1:0] {WDT_RUN, WDT_WARN, WDT_RESET} wdt_state_e;
endpackage

// [hw/wdt_prescaler.sv]
// prescaler producing the watchdog count tick
`timescale 1ns/100ps
module wdt_prescaler (
    input wire logic clock,
    input wire logic rstn,
    input wire logic run,
    input wire logic clear,
    input wire logic fastSel,
    output logic tick
);
    logic [wdt_pkg::PRE_W-1:0] preCnt_q;
    logic [wdt_pkg::PRE_W-1:0] preCnt_d;
    logic [wdt_pkg::PRE_W-1:0] limit;

    always_comb begin
        limit = fastSel ? wdt_pkg::PRE_MASK_FAST : wdt_pkg::PRE_MASK_SLOW;
        tick = run && !clear && (preCnt_q >= limit);
        if (clear || !run) begin
            preCnt_d = '0;
        end else if (tick) begin
            preCnt_d = '0;
        end else begin
            preCnt_d = preCnt_q + 14'h0001;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            preCnt_q <= '0;
        end else begin
            preCnt_q <= preCnt_d;
        end
    end
endmodule

// [tb/wdt_sys_partner.sv]
// interrupt and reset-request collector standing beside the watchdog
`timescale 1ns/100ps
module wdt_sys_partner (
    input wire logic clock,
    input wire logic resetn,
    input wire logic prewarnIrq,
    input wire logic resetRequest,
    output int warnCount,
    output logic resetEarly
);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            warnCount <= 0;
            resetEarly <= 1'b0;
        end else begin
            if (prewarnIrq === 1'b1) warnCount <= warnCount + 1;
            if (resetRequest === 1'b1 && warnCount == 0) resetEarly <= 1'b1;
        end
    end
endmodule

// [tb/watchdog_timer_bench.sv]
// self-checking bench for the watchdog timer
`timescale 1ns/100ps
module watchdog_timer_bench;
    logic clock = 1'b0, resetn = 1'b0, enIns = 1'b0, disIns = 1'b0, svc = 1'b0, fast = 1'b1;
    logic [15:0] reload = 16'hFFF0;
    logic prewarnIrq, resetRequest, running, resetEarly;
    int warnCount, n, badCount = 0, checksDone = 0;
    initial forever #2.5 clock = ~clock;
    wdt_top wdt_top_i (.clock(clock), .resetn(resetn), .watchdogEnableInstruction(enIns),
        .watchdogDisableInstruction(disIns), .serviceStrobe(svc), .fastPrescale(fast),
        .watchdogReloadValue(reload), .prewarnIrq(prewarnIrq), .resetRequest(resetRequest),
        .running(running));
    wdt_sys_partner wdt_sys_partner_i (.clock(clock), .resetn(resetn), .prewarnIrq(prewarnIrq),
        .resetRequest(resetRequest), .warnCount(warnCount), .resetEarly(resetEarly));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic doReset(input logic f, input logic [15:0] r);
        resetn <= 1'b0;
        fast <= f;
        reload <= r;
        tick(4);
        resetn <= 1'b1;
        tick(3);
    endtask
    // which: 0 service, 1 disable, otherwise enable; high for exactly one sampling edge
    task automatic pulse(input int which);
        @(posedge clock);
        case (which)
            0: svc <= 1'b1;
            1: disIns <= 1'b1;
            default: enIns <= 1'b1;
        endcase
        @(posedge clock);
        svc <= 1'b0;
        disIns <= 1'b0;
        enIns <= 1'b0;
        #1;
    endtask
    // which: 0 waits for the prewarning, otherwise for the reset request
    task automatic waitFor(input int which, input int limit);
        n = 0;
        while (((which == 0) ? prewarnIrq : resetRequest) !== 1'b1 && n < limit) begin
            tick(1);
            n++;
        end
    endtask
    task automatic testOverflow;
        doReset(1'b1, 16'hFFF0);
        check(running, 1'b1);
        pulse(0);
        waitFor(0, 5000);
        check(n >= 4090 && n <= 4110, 1'b1);
        waitFor(1, 30);
        check(n >= 16 && n <= 18, 1'b1);
        check(resetEarly, 1'b0);
    endtask
    task automatic testService;
        doReset(1'b1, 16'hFFFE);
        repeat (8) begin
            pulse(0);
            tick(400);
        end
        check(warnCount, 0);
        pulse(0);
        waitFor(0, 700);
        check(n >= 505 && n <= 520, 1'b1);
    endtask
    task automatic testDisable;
        doReset(1'b1, 16'hFFFF);
        pulse(0);
        pulse(1);
        check(running, 1'b0);
        tick(1000);
        check(warnCount, 0);
        pulse(2);
        check(running, 1'b1);
        waitFor(0, 400);
        check(n <= 300, 1'b1);
    endtask
    task automatic testSlow;
        doReset(1'b0, 16'hFFFF);
        pulse(0);
        waitFor(0, 17000);
        check(n >= 16380 && n <= 16400, 1'b1);
    endtask
    task automatic completeRun;
        if (badCount == 0 && checksDone > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #400000;
        badCount++;
        completeRun();
    end
    initial begin
        testOverflow();
        testService();
        testDisable();
        testSlow();
        completeRun();
    end
endmodule
